// *** design/iwle_unit.sv ***
// Function
// - Software interrupt vectors to 0x001, clears enable.
// - Enable/disable instructions control global enable.
// - Return-from-interrupt sets global enable again.
// - Event sets flag; only writing zero clears.
// - Flag reads set only when enabled.
// - Enabled pending flag vectors to 0x008.
// - Six hardware interrupt sources are supported.
// - Enable instruction in handler permits nesting.
// - Timer0 overflow sets timer0 flag.
// - Timer1 underflow sets timer1 flag.
// - Enabled input pin change sets port flag.
// - External select disables pin zero change.
// - Selected edge on pin zero sets flag.
// - Detector works only enabled; four-bit threshold.
// - Detector falling output sets low-voltage flag.
// - Detector present state readable as status.
// - Config and run bit start the watchdog.
// - Timeout resets or interrupts; clears timeout status.
// - Four base periods on own oscillator.
// - Assigned prescaler lengthens the watchdog period.
// - Clear-watchdog clears counter, prescaler; sets status.
// - Interrupt-mode expiry sets watchdog flag.
// - Timer0 flag sits at bit zero.
// - Timer1 flag sits at bit three.
// - Halt clears powerdown, sets timeout, clears watchdog counter but not prescaler.
`timescale 1ns/100ps
`default_nettype none

module iwle_unit (
  // Clock and reset.
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_b,
  // Instruction strobes from the core.
  input  wire logic                 i_int_instr,
  input  wire logic                 i_enable_irq_instr,
  input  wire logic                 i_disable_irq_instr,
  input  wire logic                 i_return_from_irq_instr,
  input  wire logic                 i_clear_watchdog_instr,
  input  wire logic                 i_halt_enter,
  // Flag and enable registers.
  input  wire logic                 i_flag_wr,
  input  wire logic [7:0]           i_flag_wdata,
  input  wire logic [7:0]           i_irq_enable_reg,
  // Event sources.
  input  wire logic                 i_timer0_overflow,
  input  wire logic                 i_timer1_underflow,
  input  wire logic [5:0]           i_port_pin,
  input  wire logic [5:0]           i_pin_is_input,
  input  wire logic [5:0]           i_pin_wake_enable,
  input  wire logic                 i_ext_irq_select,
  input  wire logic                 i_ext_edge_select,
  // Low-voltage detector.
  input  wire logic                 i_lvd_out,
  input  wire logic                 i_low_voltage_detect_en,
  input  wire logic [3:0]           i_lvd_sel,
  // Watchdog.
  input  wire logic                 i_wdt_osc,
  input  wire logic                 i_watchdog_run_enable,
  input  wire iwle_pkg::iwle_wdt_cfg_t i_wdt_cfg,
  // Core side results.
  output logic                      o_vector_fetch,
  output logic [9:0]                o_vector_addr,
  output logic                      o_global_irq_enable,
  output logic [7:0]                o_irq_flag_read,
  // Status and analog control.
  output logic                      o_timeout_status_n,
  output logic                      o_powerdown_status_n,
  output logic                      o_wdt_reset,
  output logic                      o_lvd_state,
  output logic                      o_lvd_enable,
  output logic [3:0]                o_lvd_level
);

  logic [7:0]                       flags;
  logic [7:0]                       next_flags;
  logic                             global_irq_enable;
  logic                             next_gie;
  logic [5:0]                       pin_meta;
  logic [5:0]                       pin_sync;
  logic [5:0]                       pin_prev;
  logic [1:0]                       misc_meta;
  logic [1:0]                       misc_sync;
  logic [1:0]                       misc_prev;
  logic [2:0]                       arm_pipe;
  logic [iwle_pkg::WDT_COUNT_W-1:0] wdt_count;
  logic [iwle_pkg::WDT_COUNT_W-1:0] next_wdt_count;
  logic [7:0]                       presc;
  logic [7:0]                       next_presc;
  logic                             timeout_n;
  logic                             powerdown_n;

  // Pin and detector synchronisers.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_meta  <= 6'h00;
      pin_sync  <= 6'h00;
      pin_prev  <= 6'h00;
      misc_meta <= 2'h0;
      misc_sync <= 2'h0;
      misc_prev <= 2'h0;
      arm_pipe  <= 3'h0;
    end else begin
      pin_meta  <= i_port_pin;
      pin_sync  <= pin_meta;
      pin_prev  <= pin_sync;
      misc_meta <= {i_wdt_osc, i_lvd_out};
      misc_sync <= misc_meta;
      misc_prev <= misc_sync;
      arm_pipe  <= {arm_pipe[1:0], 1'b1};
    end
  end

  wire       lvd_now  = misc_sync[0];
  wire       lvd_prev = misc_prev[0];
  wire       osc_tick = misc_sync[1] & ~misc_prev[1];
  // Edge detectors stay quiet until every stage holds a real pin sample, so an idle-high pin gives no edge.
  wire       armed    = arm_pipe[2];

  // Port change detection per pin.
  wire [5:0] pin_change;
  genvar gi;
  generate
    for (gi = 0; gi < iwle_pkg::PORT_PINS; gi++) begin : g_pin
      if (gi == 0) begin : g_zero
        assign pin_change[gi] = (pin_sync[gi] ^ pin_prev[gi]) & i_pin_is_input[gi] &
                                i_pin_wake_enable[gi] & ~i_ext_irq_select & armed;
      end else begin : g_other
        assign pin_change[gi] = (pin_sync[gi] ^ pin_prev[gi]) & i_pin_is_input[gi] &
                                i_pin_wake_enable[gi] & armed;
      end
    end
  endgenerate

  wire ext_rise = pin_sync[0] & ~pin_prev[0];
  wire ext_fall = ~pin_sync[0] & pin_prev[0];
  wire ext_edge = armed & i_ext_irq_select & (i_ext_edge_select ? ext_rise : ext_fall);
  wire lvd_fall = armed & i_low_voltage_detect_en & lvd_prev & ~lvd_now;

  // Watchdog base period and prescaler selection.
  wire wdt_running = i_wdt_cfg.enable & i_watchdog_run_enable;
  wire [iwle_pkg::WDT_COUNT_W-1:0] base_ticks =
      (i_wdt_cfg.period == 2'h0) ? iwle_pkg::WDT_TICKS0 :
      (i_wdt_cfg.period == 2'h1) ? iwle_pkg::WDT_TICKS1 :
      (i_wdt_cfg.period == 2'h2) ? iwle_pkg::WDT_TICKS2 : iwle_pkg::WDT_TICKS3;
  wire [iwle_pkg::WDT_COUNT_W-1:0] base_last = base_ticks - 12'h001;
  wire presc_on = i_wdt_cfg.prescaler_assign_to_watchdog;
  wire [3:0] shift_amt = {1'b0, i_wdt_cfg.prescaler_ratio_sel} + {3'h0, i_wdt_cfg.irq_mode};
  wire [8:0] presc_div = 9'h001 << shift_amt;
  wire [8:0] presc_div_last = presc_div - 9'h001;
  wire [7:0] presc_last = presc_on ? presc_div_last[7:0] : 8'h00;
  wire base_done = wdt_running & osc_tick & (wdt_count == base_last);
  wire wdt_expire = base_done & (presc == presc_last);
  wire wdt_clear = i_clear_watchdog_instr | i_halt_enter;

  always_comb begin
    if (wdt_clear || !wdt_running || base_done) begin
      next_wdt_count = '0;
    end else if (osc_tick) begin
      next_wdt_count = wdt_count + 12'h001;
    end else begin
      next_wdt_count = wdt_count;
    end
  end

  always_comb begin
    if ((i_clear_watchdog_instr && presc_on) || !presc_on || !wdt_running || wdt_expire) begin
      next_presc = 8'h00;
    end else if (base_done) begin
      next_presc = presc + 8'h01;
    end else begin
      next_presc = presc;
    end
  end

  // Flag set and clear vectors.
  wire [7:0] set_vec;
  assign set_vec[iwle_pkg::FLAG_TIMER0]      = i_timer0_overflow;
  assign set_vec[iwle_pkg::FLAG_PORT_CHANGE] = |pin_change;
  assign set_vec[iwle_pkg::FLAG_EXT_PIN]     = ext_edge;
  assign set_vec[iwle_pkg::FLAG_TIMER1]      = i_timer1_underflow;
  assign set_vec[5:4]                        = 2'h0;
  assign set_vec[iwle_pkg::FLAG_WATCHDOG]    = wdt_expire & i_wdt_cfg.irq_mode;
  assign set_vec[iwle_pkg::FLAG_LOW_VOLTAGE] = lvd_fall;
  wire [7:0] clr_vec = i_flag_wr ? ~i_flag_wdata : 8'h00;
  assign next_flags = ((flags & ~clr_vec) | set_vec) & iwle_pkg::FLAG_USED_MASK;

  // Interrupt acceptance.
  wire hw_pending = |(flags & i_irq_enable_reg);
  wire take_sw = i_int_instr;
  wire take_hw = global_irq_enable & hw_pending & ~i_int_instr;

  always_comb begin
    if (take_sw || take_hw) begin
      next_gie = 1'b0;
    end else if (i_enable_irq_instr || i_return_from_irq_instr) begin
      next_gie = 1'b1;
    end else if (i_disable_irq_instr) begin
      next_gie = 1'b0;
    end else begin
      next_gie = global_irq_enable;
    end
  end

  wire [3:0] lvd_level_dec = (i_lvd_sel[3:2] == 2'h3) ? 4'ha :
                             (i_lvd_sel[3:1] == 3'h5) ? 4'h9 :
                             (i_lvd_sel[3:1] == 3'h4) ? 4'h8 : i_lvd_sel;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags     <= iwle_pkg::FLAG_RESET;
      global_irq_enable       <= iwle_pkg::GIE_RESET;
      wdt_count <= '0;
      presc     <= 8'h00;
    end else begin
      flags     <= next_flags;
      global_irq_enable       <= next_gie;
      wdt_count <= next_wdt_count;
      presc     <= next_presc;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timeout_n   <= iwle_pkg::TIMEOUT_N_RESET;
      powerdown_n <= iwle_pkg::POWERDOWN_N_RESET;
    end else begin
      if (wdt_expire) begin
        timeout_n <= 1'b0;
      end else if (wdt_clear) begin
        timeout_n <= 1'b1;
      end
      if (i_halt_enter) begin
        powerdown_n <= 1'b0;
      end else if (i_clear_watchdog_instr) begin
        powerdown_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_vector_fetch  <= 1'b0;
      o_vector_addr   <= 10'h000;
      o_irq_flag_read <= 8'h00;
      o_wdt_reset     <= 1'b0;
      o_lvd_state     <= 1'b0;
      o_lvd_enable    <= 1'b0;
      o_lvd_level     <= 4'h0;
    end else begin
      o_vector_fetch  <= take_sw | take_hw;
      o_vector_addr   <= take_sw ? iwle_pkg::VECTOR_SOFTWARE : iwle_pkg::VECTOR_HARDWARE;
      o_irq_flag_read <= next_flags & i_irq_enable_reg;
      o_wdt_reset     <= wdt_expire & ~i_wdt_cfg.irq_mode;
      o_lvd_state     <= lvd_now & i_low_voltage_detect_en;
      o_lvd_enable    <= i_low_voltage_detect_en;
      o_lvd_level     <= lvd_level_dec;
    end
  end

  assign o_global_irq_enable  = global_irq_enable;
  assign o_timeout_status_n   = timeout_n;
  assign o_powerdown_status_n = powerdown_n;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  sw_vector_a: assert property (i_int_instr |=> o_vector_fetch && o_vector_addr == 10'h001 && !global_irq_enable)
    else $error("software interrupt did not vector to 0x001");

  gie_enable_a: assert property ((i_enable_irq_instr && !i_int_instr && !take_hw) |=> global_irq_enable)
    else $error("enable instruction did not set global enable");

  gie_disable_a: assert property ((i_disable_irq_instr && !i_enable_irq_instr && !i_return_from_irq_instr)
                                  |=> !global_irq_enable)
    else $error("disable instruction did not clear global enable");

  return_gie_a: assert property ((i_return_from_irq_instr && !i_int_instr && !take_hw) |=> global_irq_enable)
    else $error("return did not set global enable");

  flag_hold_a: assert property ((flags[0] && !(i_flag_wr && !i_flag_wdata[0])) |=> flags[0])
    else $error("timer0 flag dropped without a zero write");

  flag_read_a: assert property (##1 o_irq_flag_read == (flags & $past(i_irq_enable_reg)))
    else $error("flag read not masked by enable");

  hw_vector_a: assert property ((global_irq_enable && |(flags & i_irq_enable_reg) && !i_int_instr)
                                |=> o_vector_fetch && o_vector_addr == 10'h008 && !global_irq_enable)
    else $error("hardware interrupt did not vector to 0x008");

  timer0_set_a: assert property (i_timer0_overflow |=> flags[0])
    else $error("timer0 overflow did not set flag");

  timer1_set_a: assert property (i_timer1_underflow |=> flags[3])
    else $error("timer1 underflow did not set flag");

  set_wins_a: assert property ((i_timer1_underflow && i_flag_wr && !i_flag_wdata[3]) |=> flags[3])
    else $error("simultaneous clear lost an event");

  pin_zero_mask_a: assert property (i_ext_irq_select |-> !pin_change[0])
    else $error("pin zero change seen while external select set");

  lvd_fall_a: assert property ((armed && i_low_voltage_detect_en && lvd_prev && !lvd_now) |=> flags[7])
    else $error("detector fall did not set flag");

  wdt_timeout_a: assert property (wdt_expire |=> !o_timeout_status_n ##0
                                  (o_wdt_reset == !$past(i_wdt_cfg.irq_mode)))
    else $error("watchdog timeout effect wrong");

  wdt_flag_a: assert property ((wdt_expire && i_wdt_cfg.irq_mode) |=> flags[6])
    else $error("watchdog flag not set in interrupt mode");

  wdt_clear_a: assert property ((i_clear_watchdog_instr && !wdt_expire)
                                |=> o_timeout_status_n && wdt_count == '0)
    else $error("clear-watchdog did not clear counter");

  halt_entry_a: assert property ((i_halt_enter && !wdt_expire)
                                 |=> !o_powerdown_status_n && o_timeout_status_n && wdt_count == '0)
    else $error("halt entry status wrong");

  wdt_stopped_a: assert property (!wdt_running |=> wdt_count == '0 && !$rose(o_wdt_reset))
    else $error("watchdog ran while stopped");

  sw_over_hw_a: assert property ((i_int_instr && global_irq_enable && |(flags & i_irq_enable_reg))
                                 |=> o_vector_addr == 10'h001)
    else $error("software interrupt lost to a hardware request");

  port_change_a: assert property ((|pin_change) |=> flags[1])
    else $error("enabled pin change did not set port flag");

  ext_fall_a: assert property ((armed && i_ext_irq_select && !i_ext_edge_select &&
                                !pin_sync[0] && pin_prev[0]) |=> flags[2])
    else $error("falling edge on pin zero did not set flag");

  lvd_off_a: assert property (!i_low_voltage_detect_en |=> !o_lvd_state && !$rose(flags[7]))
    else $error("disabled detector still reported");

  lvd_top_code_a: assert property ((i_lvd_sel[3:2] == 2'h3) |=> o_lvd_level == 4'ha)
    else $error("top threshold codes not merged");

  irq_div_min_a: assert property ((presc_on && i_wdt_cfg.irq_mode && base_done && presc == 8'h00)
                                  |-> !wdt_expire)
    else $error("interrupt-mode watchdog expired after one base period");

endmodule

`default_nettype wire

// *** design/iwle_pkg.sv ***
`default_nettype none

package iwle_pkg;

  // Flag register layout and the bits that hardware can set.
  localparam int unsigned FLAG_TIMER0       = 0;
  localparam int unsigned FLAG_PORT_CHANGE  = 1;
  localparam int unsigned FLAG_EXT_PIN      = 2;
  localparam int unsigned FLAG_TIMER1       = 3;
  localparam int unsigned FLAG_WATCHDOG     = 6;
  localparam int unsigned FLAG_LOW_VOLTAGE  = 7;
  localparam logic [7:0]  FLAG_USED_MASK    = 8'hcf;
  localparam logic [7:0]  FLAG_RESET        = 8'h00;

  // Instruction fetch vectors.
  localparam logic [9:0]  VECTOR_SOFTWARE   = 10'h001;
  localparam logic [9:0]  VECTOR_HARDWARE   = 10'h008;

  // Values after reset of the control and status bits.
  localparam logic        GIE_RESET         = 1'b0;
  localparam logic        TIMEOUT_N_RESET   = 1'b1;
  localparam logic        POWERDOWN_N_RESET = 1'b1;

  // Watchdog oscillator rate and base periods in tenths of a millisecond.
  localparam int unsigned WDT_OSC_HZ        = 16000;
  localparam int unsigned WDT_PERIOD0_TMS   = 35;
  localparam int unsigned WDT_PERIOD1_TMS   = 150;
  localparam int unsigned WDT_PERIOD2_TMS   = 600;
  localparam int unsigned WDT_PERIOD3_TMS   = 2500;
  localparam int unsigned WDT_COUNT_W       = 12;
  localparam logic [WDT_COUNT_W-1:0] WDT_TICKS0 = WDT_COUNT_W'(WDT_PERIOD0_TMS * WDT_OSC_HZ / 10000);
  localparam logic [WDT_COUNT_W-1:0] WDT_TICKS1 = WDT_COUNT_W'(WDT_PERIOD1_TMS * WDT_OSC_HZ / 10000);
  localparam logic [WDT_COUNT_W-1:0] WDT_TICKS2 = WDT_COUNT_W'(WDT_PERIOD2_TMS * WDT_OSC_HZ / 10000);
  localparam logic [WDT_COUNT_W-1:0] WDT_TICKS3 = WDT_COUNT_W'(WDT_PERIOD3_TMS * WDT_OSC_HZ / 10000);

  // Number of port pins watched for a level change.
  localparam int unsigned PORT_PINS         = 6;

  // Watchdog configuration taken from configuration and run-time bits.
  typedef struct packed {
    logic       enable;
    logic       irq_mode;
    logic [1:0] period;
    logic       prescaler_assign_to_watchdog;
    logic [2:0] prescaler_ratio_sel;
  } iwle_wdt_cfg_t;

endpackage

`default_nettype wire

// *** dv/iwle_far_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module iwle_far_model (
  // Clock.
  input  wire logic i_clock,
  // Supply condition set by the bench.
  input  wire logic i_supply_low,
  // Detector output and free-running watchdog oscillator.
  output logic      o_lvd_out,
  output logic      o_wdt_osc
);
  logic [1:0] div = 2'h0;

  always @(posedge i_clock) begin
    div <= div + 2'h1;
  end

  // The oscillator never stops, whatever the core does.
  assign o_wdt_osc = div[1];
  assign o_lvd_out = ~i_supply_low;
endmodule

`default_nettype wire

// *** dv/iwle_unit_test.sv ***
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module iwle_unit_test;
  logic                    i_clock, i_rst_b, flag_wr, ext_sel, ext_edge, lvd_en, supply_low, wdt_run;
  logic [5:0]              instr, pin, pin_in, pin_wake;
  logic [1:0]              tmr;
  logic [7:0]              wdata, irq_en, flags;
  logic [3:0]              lvd_sel, lvd_lvl, e;
  iwle_pkg::iwle_wdt_cfg_t cfg;
  logic                    lvd_out, wdt_osc, fetch, global_irq_enable, to_n, pd_n, wdt_rst, lvd_state, lvd_on;
  logic [9:0]              vaddr, want;
  logic [9:0]              exp_q[$];
  int                      n_fail, samples_checked, n, tk;

  iwle_far_model far_u (.i_clock(i_clock), .i_supply_low(supply_low), .o_lvd_out(lvd_out), .o_wdt_osc(wdt_osc));

  iwle_unit dut_u (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_int_instr(instr[0]), .i_enable_irq_instr(instr[1]),
    .i_disable_irq_instr(instr[2]), .i_return_from_irq_instr(instr[3]), .i_clear_watchdog_instr(instr[4]),
    .i_halt_enter(instr[5]), .i_flag_wr(flag_wr), .i_flag_wdata(wdata), .i_irq_enable_reg(irq_en),
    .i_timer0_overflow(tmr[0]), .i_timer1_underflow(tmr[1]), .i_port_pin(pin), .i_pin_is_input(pin_in),
    .i_pin_wake_enable(pin_wake), .i_ext_irq_select(ext_sel), .i_ext_edge_select(ext_edge), .i_lvd_out(lvd_out),
    .i_low_voltage_detect_en(lvd_en), .i_lvd_sel(lvd_sel), .i_wdt_osc(wdt_osc), .i_watchdog_run_enable(wdt_run),
    .i_wdt_cfg(cfg), .o_vector_fetch(fetch), .o_vector_addr(vaddr), .o_global_irq_enable(global_irq_enable),
    .o_irq_flag_read(flags), .o_timeout_status_n(to_n), .o_powerdown_status_n(pd_n), .o_wdt_reset(wdt_rst),
    .o_lvd_state(lvd_state), .o_lvd_enable(lvd_on), .o_lvd_level(lvd_lvl));

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  task automatic give_verdict(input bit hung);
    if (hung) n_fail++;
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clock);
    @(negedge i_clock);
  endtask

  task automatic op(input int k);
    @(posedge i_clock);
    instr[k] <= 1'b1;
    @(posedge i_clock);
    instr[k] <= 1'b0;
    @(negedge i_clock);
  endtask

  task automatic src(input logic [1:0] s);
    @(posedge i_clock);
    tmr <= s;
    @(posedge i_clock);
    tmr <= 2'h0;
  endtask

  task automatic wr(input logic [7:0] d);
    @(posedge i_clock);
    flag_wr <= 1'b1;
    wdata <= d;
    @(posedge i_clock);
    flag_wr <= 1'b0;
    cyc(1);
  endtask

  task automatic wait_flag(input int b);
    int i;
    for (i = 0; i < 12 && flags[b] !== 1'b1; i++) @(negedge i_clock);
    if (i == 12) give_verdict(1);
  endtask

  task automatic wdt_time(output int t);
    for (t = 0; t < 17000 && wdt_rst !== 1'b1 && flags[6] !== 1'b1; t++) @(negedge i_clock);
    if (t == 17000) give_verdict(1);
  endtask

  // Each fetch pops the oldest noted vector; an unnoted fetch compares against an impossible one.
  always @(negedge i_clock) begin
    if (i_rst_b === 1'b1 && fetch !== 1'b0) begin
      want = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3ff;
      `CHK(vaddr, want)
    end
  end

  initial begin
    i_rst_b = 1'b0; instr = 6'h00; flag_wr = 1'b0; wdata = 8'hff; irq_en = 8'hcf; tmr = 2'h0;
    pin = 6'h00; pin_in = 6'h3f; pin_wake = 6'h09; ext_sel = 1'b1; ext_edge = 1'b1; lvd_en = 1'b0;
    supply_low = 1'b0; lvd_sel = 4'h0; wdt_run = 1'b0; cfg = '0; n_fail = 0; samples_checked = 0;
    void'($urandom(53684));
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    cyc(1);
    `CHK({global_irq_enable, to_n, pd_n, flags}, 11'h300)
    op(1);
    `CHK(global_irq_enable, 1'b1)
    exp_q.push_back(iwle_pkg::VECTOR_SOFTWARE);
    op(0);
    `CHK(global_irq_enable, 1'b0)
    op(1);
    op(2);
    `CHK(global_irq_enable, 1'b0)
    src(2'h1);
    wait_flag(0);
    `CHK(flags, 8'h01)
    src(2'h2);
    wait_flag(3);
    `CHK(flags, 8'h09)
    @(posedge i_clock) pin[0] <= 1'b1;
    wait_flag(2);
    cyc(3);
    `CHK(flags[2:1], 2'b10)
    @(posedge i_clock) pin[3] <= 1'b1;
    wait_flag(1);
    @(posedge i_clock) lvd_en <= 1'b1;
    cyc(5);
    `CHK({lvd_state, lvd_on}, 2'b11)
    @(posedge i_clock) supply_low <= 1'b1;
    wait_flag(7);
    `CHK(lvd_state, 1'b0)
    @(posedge i_clock) irq_en <= 8'h00;
    cyc(2);
    `CHK(flags, 8'h00)
    @(posedge i_clock) irq_en <= 8'hcf;
    cyc(2);
    `CHK(flags, 8'h8f)
    wr(8'hff);
    `CHK(flags, 8'h8f)
    wr(8'h00);
    @(posedge i_clock);
    tmr <= 2'h1;
    flag_wr <= 1'b1;
    @(posedge i_clock);
    tmr <= 2'h0;
    flag_wr <= 1'b0;
    cyc(1);
    `CHK(flags, 8'h01)
    src(2'h2);
    exp_q.push_back(iwle_pkg::VECTOR_HARDWARE);
    op(1);
    cyc(2);
    `CHK({global_irq_enable, flags}, 9'h009)
    exp_q.push_back(iwle_pkg::VECTOR_HARDWARE);
    op(1);
    cyc(2);
    `CHK(exp_q.size(), 0)
    wr(8'h00);
    op(3);
    cyc(3);
    `CHK(global_irq_enable, 1'b1)
    op(2);
    @(posedge i_clock) begin
      ext_edge <= 1'b0;
      pin[0]   <= 1'b0;
    end
    wait_flag(2);
    cyc(3);
    `CHK(flags, 8'h04)
    @(posedge i_clock) begin
      ext_sel <= 1'b0;
      pin[0]  <= 1'b1;
    end
    wait_flag(1);
    cyc(3);
    `CHK(flags, 8'h06)
    wr(8'h00);
    repeat (8) begin
      @(posedge i_clock) lvd_sel <= 4'($urandom());
      cyc(3);
      e = (lvd_sel >= 4'hc) ? 4'ha : (lvd_sel >= 4'ha) ? 4'h9 : (lvd_sel >= 4'h8) ? 4'h8 : lvd_sel;
      `CHK(lvd_lvl, e)
    end
    @(posedge i_clock);
    cfg <= '{enable: 1'b1, irq_mode: 1'b0, period: 2'h0, prescaler_assign_to_watchdog: 1'b0,
             prescaler_ratio_sel: 3'h0};
    wdt_run <= 1'b1;
    wdt_time(n);
    `CHK({wdt_rst, flags[6]}, 2'b10)
    `CHK(n inside {[4 * iwle_pkg::WDT_TICKS0 - 12 : 4 * iwle_pkg::WDT_TICKS0 + 12]}, 1'b1)
    cyc(1);
    `CHK(to_n, 1'b0)
    op(4);
    `CHK(to_n, 1'b1)
    op(5);
    `CHK({pd_n, to_n}, 2'b01)
    @(posedge i_clock) wdt_run <= 1'b0;
    cyc(300);
    `CHK({to_n, flags[6]}, 2'b10)
    @(posedge i_clock) begin
      wdt_run    <= 1'b1;
      cfg.enable <= 1'b0;
    end
    cyc(300);
    `CHK({to_n, flags[6]}, 2'b10)
    @(posedge i_clock);
    cfg <= '{enable: 1'b1, irq_mode: 1'b1, period: 2'h0, prescaler_assign_to_watchdog: 1'b1,
             prescaler_ratio_sel: 3'h0};
    wdt_run <= 1'b1;
    wdt_time(n);
    `CHK({wdt_rst, flags[6]}, 2'b01)
    `CHK(n inside {[8 * iwle_pkg::WDT_TICKS0 - 12 : 8 * iwle_pkg::WDT_TICKS0 + 12]}, 1'b1)
    cyc(1);
    `CHK({flags[6], to_n, wdt_rst}, 3'b100)
    for (int p = 1; p < 4; p++) begin
      @(posedge i_clock) wdt_run <= 1'b0;
      cfg <= '{enable: 1'b1, irq_mode: 1'b0, period: 2'(p), prescaler_assign_to_watchdog: 1'b0,
               prescaler_ratio_sel: 3'h0};
      wr(8'h00);
      @(posedge i_clock) wdt_run <= 1'b1;
      wdt_time(n);
      tk = (p == 1) ? iwle_pkg::WDT_TICKS1 : (p == 2) ? iwle_pkg::WDT_TICKS2 : iwle_pkg::WDT_TICKS3;
      `CHK(n inside {[4 * tk - 12 : 4 * tk + 12]}, 1'b1)
    end
    give_verdict(0);
  end
endmodule

`default_nettype wire
